// [core/pric_consts.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the remote I/O control
// Assumes: 25 MHz reference clock
// Notes:   Register offsets are byte addresses of 32-bit words
`ifndef PRIC_CONSTS_SVH
`define PRIC_CONSTS_SVH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define PRIC_CLK_HZ        25000000
`define PRIC_ACK_TIME_MS   500
`define PRIC_ACK_CYC       (`PRIC_ACK_TIME_MS * (`PRIC_CLK_HZ / 1000))
`define PRIC_BAUD          9600
`define PRIC_BAUD_CYC      (`PRIC_CLK_HZ / `PRIC_BAUD)
`define PRIC_FILT_TIME_US  1000
`define PRIC_FILT_CYC      (`PRIC_FILT_TIME_US * (`PRIC_CLK_HZ / 1000000))
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PRIC_OFS_CTRL      8'h00
`define PRIC_OFS_STANDBY   8'h04
`define PRIC_OFS_SWPOINT   8'h08
`define PRIC_OFS_NODE      8'h0C
`define PRIC_OFS_STATUS    8'h10
`define PRIC_OFS_RXDATA    8'h14
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PRIC_CTRL_R1INV    8
`define PRIC_STANDBY_RST   10'h029B
`define PRIC_SWPOINT_RST   10'h0320
`define PRIC_NODE_RST      10'h0001
`define PRIC_GROUP_ADDR    10'h03C2
`define PRIC_FULL_SPEED    10'h03E8
`define PRIC_MIN_SPEED     10'h00C8
`define PRIC_SET_MIN_MV    14'h07D0
`define PRIC_SET_MAX_MV    14'h2710
`endif

// [core/pric_pkg.sv]
// Purpose: Types of the remote I/O control
// Assumes: Nothing beyond the constants header
// Notes:   One-hot state codes written out
package pric_pkg;
   // ----------------------------------------
   // Serial receiver states
   // ----------------------------------------
   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA  = 4'b0100,
      RX_STOP  = 4'b1000
   } pric_rx_state_type;
endpackage

// [core/pric_remote_io.sv]
// Purpose: Remote connector command filter, pump control, status outputs, serial characters
// Assumes: Inputs other than the command pins and rx_i synchronous to ref_clk_i; setpoint arrives in millivolts
// Notes:   Speeds are in permille of nominal speed
//
// Functional notes
// R01 - Command inputs are active high
// R02 - Venting only while vent enable asserted
// R03 - Motor runs with station, self-test, motor
// R04 - Motor toggle does not trigger venting
// R05 - Station on acknowledges faults whose cause left
// R06 - Reduced speed input selects standby speed
// R07 - Heater follows heating input
// R08 - Sealing gas valve follows its input
// R09 - Fault clear needs 500 ms pulse
// R10 - Override input gives connector command priority
// R11 - Setpoint 2-10 V maps to 20-100 %
// R12 - Setpoint below 2 V means full speed
// R13 - Speed reached output at switch point
// R14 - Fault free output low on any fault
// R15 - Priority output shows connector priority
// R16 - Analog output proportional to actual speed
// R17 - Relay one at switch point, invertible
// R18 - Relay two energised while fault free
// R19 - Relay three energised on any warning
// R20 - Serial characters 9600 baud, 8N1
// R21 - Respond to group address and node
// R22 - Every bus unit needs distinct address
// R23 - Synchronise and debounce every command input
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "pric_consts.svh"
module pric_remote_io #(
   parameter int NF       = 8,
   parameter int NW       = 4,
   parameter int DAC_W    = 10,
   parameter int ACK_CYC  = `PRIC_ACK_CYC,
   parameter int FILT_CYC = `PRIC_FILT_CYC
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_i,
   input  wire logic              vent_enable_input_i,
   input  wire logic              motor_run_input_i,
   input  wire logic              station_on_input_i,
   input  wire logic              reduced_speed_input_i,
   input  wire logic              heater_on_input_i,
   input  wire logic              seal_gas_input_i,
   input  wire logic              fault_clear_input_i,
   input  wire logic              connector_override_input_i,
   input  wire logic [13:0]       speed_setpoint_analog_i,
   input  wire logic [9:0]        actual_speed_i,
   input  wire logic              selftest_ok_i,
   input  wire logic              vent_request_i,
   input  wire logic [NF-1:0]     fault_cause_i,
   input  wire logic [NW-1:0]     warning_i,
   input  wire logic              rx_i,
   input  wire logic [9:0]        rx_addr_i,
   input  wire logic              rx_addr_stb_i,
   input  wire logic [7:0]        reg_addr_i,
   input  wire logic [31:0]       reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic [31:0]            reg_rdata_o,
   output logic                   motor_run_o,
   output logic                   station_on_o,
   output logic                   vent_o,
   output logic                   heater_o,
   output logic                   seal_gas_o,
   output logic [9:0]             target_speed_o,
   output logic                   speed_reached_output_o,
   output logic                   fault_free_output_o,
   output logic                   priority_o,
   output logic [DAC_W-1:0]       speed_analog_output_o,
   output logic                   relay1_o,
   output logic                   relay2_o,
   output logic                   relay3_o,
   output logic [7:0]             rx_data_o,
   output logic                   rx_valid_o,
   output logic                   addr_match_o
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   localparam int ACK_W = $clog2(ACK_CYC + 1);
   localparam int FLT_W = $clog2(FILT_CYC + 1);
   localparam int BD_W  = 12;
   logic [7:0]                raw_cmd;
   logic [7:0]                sync1_reg;
   logic [7:0]                sync2_reg;
   logic [7:0]                filt_reg;
   logic [FLT_W-1:0]          filt_cnt_reg [8];
   logic [7:0]                sw_cmd_reg;
   logic                      r1_inv_reg;
   logic [9:0]                standby_reg;
   logic [9:0]                swpoint_reg;
   logic [9:0]                node_reg;
   logic [7:0]                eff;
   logic                      station_dly_reg;
   logic                      station_ack;
   logic [ACK_W-1:0]          ack_cnt_reg;
   logic                      ack_pulse;
   logic                      ack;
   logic [NF-1:0]             fault_reg;
   logic                      vent_pend_reg;
   logic [13:0]               set_mv;
   logic [9:0]                speed_next;
   logic [DAC_W+9:0]          dac_prod;
   logic                      rx_s1_reg;
   logic                      rx_s2_reg;
   pric_pkg::pric_rx_state_type rx_state_reg;
   logic [BD_W-1:0]           bd_cnt_reg;
   logic [2:0]                bit_cnt_reg;
   logic [7:0]                shift_reg;
   logic                      bd_tick;
   assign raw_cmd = {connector_override_input_i, fault_clear_input_i, seal_gas_input_i,
                     heater_on_input_i, reduced_speed_input_i, station_on_input_i,
                     motor_run_input_i, vent_enable_input_i};
   // ----------------------------------------
   // Input conditioning
   // ----------------------------------------
   // R23 two-stage synchroniser
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
      end else begin
         sync1_reg <= raw_cmd;
         sync2_reg <= sync1_reg;
      end
   end
   // R01 active high inputs after a stable debounce interval
   // R23 per-input debounce filter
   for (genvar i = 0; i < 8; i++) begin : g_filt
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
         if (rst_i) begin
            filt_cnt_reg[i] <= '0;
            filt_reg[i]     <= 1'b0;
         end else if (sync2_reg[i] == filt_reg[i]) begin
            filt_cnt_reg[i] <= '0;
         end else if (filt_cnt_reg[i] == FLT_W'(FILT_CYC - 1)) begin
            filt_cnt_reg[i] <= '0;
            filt_reg[i]     <= sync2_reg[i];
         end else begin
            filt_cnt_reg[i] <= filt_cnt_reg[i] + 1'b1;
         end
      end
   end
   // R10 connector wins while override held, else software commands
   assign eff = filt_reg[7] ? filt_reg : {1'b0, sw_cmd_reg[6:0]};
   // ----------------------------------------
   // Register port
   // ----------------------------------------
   // Software command word; a stale command resumes when override drops, override is pin only
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sw_cmd_reg  <= 8'h00;
         r1_inv_reg  <= 1'b0;
         standby_reg <= `PRIC_STANDBY_RST;
         swpoint_reg <= `PRIC_SWPOINT_RST;
         node_reg    <= `PRIC_NODE_RST;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `PRIC_OFS_CTRL: begin
               sw_cmd_reg <= reg_wdata_i[7:0];
               r1_inv_reg <= reg_wdata_i[`PRIC_CTRL_R1INV];
            end
            `PRIC_OFS_STANDBY: standby_reg <= reg_wdata_i[9:0];
            `PRIC_OFS_SWPOINT: swpoint_reg <= reg_wdata_i[9:0];
            `PRIC_OFS_NODE:    node_reg    <= reg_wdata_i[9:0];
            default: ;
         endcase
      end
   end
   // Read data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `PRIC_OFS_CTRL:    reg_rdata_o <= {23'h0, r1_inv_reg, sw_cmd_reg};
            `PRIC_OFS_STANDBY: reg_rdata_o <= {22'h0, standby_reg};
            `PRIC_OFS_SWPOINT: reg_rdata_o <= {22'h0, swpoint_reg};
            `PRIC_OFS_NODE:    reg_rdata_o <= {22'h0, node_reg};
            `PRIC_OFS_STATUS:  reg_rdata_o <= {16'h0, 8'(fault_reg), filt_reg};
            `PRIC_OFS_RXDATA:  reg_rdata_o <= {24'h0, rx_data_o};
            default:           reg_rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end
   // ----------------------------------------
   // Fault acknowledge and fault memory
   // ----------------------------------------
   // R05 acknowledge on station switch-on edge
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         station_dly_reg <= 1'b0;
      end else begin
         station_dly_reg <= eff[2];
      end
   end
   assign station_ack = eff[2] & ~station_dly_reg;
   // R09 clear input must stay high for the full hold time; fires once
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_cnt_reg <= '0;
      end else if (!eff[6]) begin
         ack_cnt_reg <= '0;
      end else if (ack_cnt_reg != ACK_W'(ACK_CYC)) begin
         ack_cnt_reg <= ack_cnt_reg + 1'b1;
      end
   end
   assign ack_pulse = eff[6] && (ack_cnt_reg == ACK_W'(ACK_CYC - 1));
   assign ack       = ack_pulse | station_ack;
   // R05 a present cause wins over the acknowledge
   // R09 clear only faults whose cause has gone
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fault_reg <= '0;
      end else begin
         fault_reg <= fault_cause_i | (fault_reg & ~{NF{ack}});
      end
   end
   // ----------------------------------------
   // Pump commands
   // ----------------------------------------
   // R04 venting is requested by station switch-off, never by motor toggling
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         vent_pend_reg <= 1'b0;
      end else if (eff[2]) begin
         vent_pend_reg <= 1'b0;
      end else if (station_dly_reg || vent_request_i) begin
         vent_pend_reg <= 1'b1;
      end
   end
   // Command outputs registered from the effective command set
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         motor_run_o  <= 1'b0;
         station_on_o <= 1'b0;
         vent_o       <= 1'b0;
         heater_o     <= 1'b0;
         seal_gas_o   <= 1'b0;
         priority_o   <= 1'b0;
      end else begin
         // R03 motor needs station, self-test and motor command
         motor_run_o  <= eff[2] & selftest_ok_i & eff[1];
         station_on_o <= eff[2];
         // R02 venting locked while enable is open
         vent_o       <= eff[0] & vent_pend_reg;
         // R07 heater follows command
         heater_o     <= eff[4];
         // R08 seal gas valve follows command
         seal_gas_o   <= eff[5];
         // R15 priority status mirrors filtered override
         priority_o   <= filt_reg[7];
      end
   end
   // ----------------------------------------
   // Speed setpoint and speed outputs
   // ----------------------------------------
   // Clamp above 10 V so the linear map stays within full speed
   assign set_mv = (speed_setpoint_analog_i > `PRIC_SET_MAX_MV) ? `PRIC_SET_MAX_MV
                                                                 : speed_setpoint_analog_i;
   always_comb begin
      // R06 standby speed overrides setpoint
      if (eff[3]) begin
         speed_next = standby_reg;
      // R12 open or low setpoint gives full speed
      end else if (set_mv < `PRIC_SET_MIN_MV) begin
         speed_next = `PRIC_FULL_SPEED;
      // R11 8000 mV span onto 800 permille: one step per 10 mV
      end else begin
         speed_next = `PRIC_MIN_SPEED + 10'((set_mv - `PRIC_SET_MIN_MV) / 14'd10);
      end
   end
   // R16 full scale code equals full nominal speed
   assign dac_prod = DAC_W'((1 << DAC_W) - 1) * actual_speed_i;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         target_speed_o         <= `PRIC_FULL_SPEED;
         speed_analog_output_o  <= '0;
         speed_reached_output_o <= 1'b0;
         fault_free_output_o    <= 1'b1;
         relay1_o               <= 1'b0;
         relay2_o               <= 1'b1;
         relay3_o               <= 1'b0;
      end else begin
         target_speed_o         <= speed_next;
         speed_analog_output_o  <= DAC_W'(dac_prod / (DAC_W+10)'(`PRIC_FULL_SPEED));
         // R13 reached at or above switch point
         speed_reached_output_o <= actual_speed_i >= swpoint_reg;
         // R14 collective fault flag, high when clean
         fault_free_output_o    <= ~|fault_reg;
         // R17 relay one at switch point, sense invertible
         relay1_o               <= (actual_speed_i >= swpoint_reg) ^ r1_inv_reg;
         // R18 relay two energised while fault free
         relay2_o               <= ~|fault_reg;
         // R19 relay three energised on any warning
         relay3_o               <= |warning_i;
      end
   end
   // ----------------------------------------
   // Serial character receiver
   // ----------------------------------------
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
      end else begin
         rx_s1_reg <= rx_i;
         rx_s2_reg <= rx_s1_reg;
      end
   end
   assign bd_tick = (bd_cnt_reg == '0);
   // R20 8 data bits, one start, no parity at 9600 baud
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_state_reg <= pric_pkg::RX_IDLE;
         bd_cnt_reg   <= '0;
         bit_cnt_reg  <= 3'h0;
         shift_reg    <= 8'h00;
         rx_data_o    <= 8'h00;
         rx_valid_o   <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         if (!bd_tick) begin
            bd_cnt_reg <= bd_cnt_reg - 1'b1;
         end
         case (rx_state_reg)
            pric_pkg::RX_IDLE: begin
               if (!rx_s2_reg) begin
                  bd_cnt_reg   <= BD_W'(`PRIC_BAUD_CYC / 2);
                  rx_state_reg <= pric_pkg::RX_START;
               end
            end
            pric_pkg::RX_START: begin
               if (bd_tick) begin
                  // A glitch shorter than half a bit is not a start
                  rx_state_reg <= rx_s2_reg ? pric_pkg::RX_IDLE : pric_pkg::RX_DATA;
                  bd_cnt_reg   <= BD_W'(`PRIC_BAUD_CYC - 1);
                  bit_cnt_reg  <= 3'h0;
               end
            end
            pric_pkg::RX_DATA: begin
               if (bd_tick) begin
                  shift_reg   <= {rx_s2_reg, shift_reg[7:1]};
                  bd_cnt_reg  <= BD_W'(`PRIC_BAUD_CYC - 1);
                  bit_cnt_reg <= bit_cnt_reg + 1'b1;
                  if (bit_cnt_reg == 3'h7) begin
                     rx_state_reg <= pric_pkg::RX_STOP;
                  end
               end
            end
            pric_pkg::RX_STOP: begin
               if (bd_tick) begin
                  // Framing error drops the character silently
                  rx_valid_o   <= rx_s2_reg;
                  rx_data_o    <= rx_s2_reg ? shift_reg : rx_data_o;
                  rx_state_reg <= pric_pkg::RX_IDLE;
               end
            end
            default: rx_state_reg <= pric_pkg::RX_IDLE;
         endcase
      end
   end
   // R21 match own node address or fixed group address
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         addr_match_o <= 1'b0;
      end else begin
         addr_match_o <= rx_addr_stb_i &&
                         (rx_addr_i == node_reg || rx_addr_i == `PRIC_GROUP_ADDR);
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence station_rise_s;
      !eff[2] ##1 eff[2];
   endsequence
   sequence clear_held_s;
      eff[6] && ack_cnt_reg == ACK_W'(ACK_CYC - 1);
   endsequence
   chk_motor_gate: assert property (motor_run_o |-> $past(eff[2] & selftest_ok_i & eff[1])) // R03
      else $error("Motor ran without station, self-test and command");
   chk_vent_lock: assert property (!eff[0] |=> !vent_o) // R02
      else $error("Venting while enable open");
   chk_motor_novent: assert property (eff[2] && $fell(eff[1]) |=> ##1 !vent_o) // R04
      else $error("Motor stop caused venting");
   chk_station_ack: assert property (station_rise_s ##0 fault_cause_i == '0 |=> fault_reg == '0) // R05
      else $error("Station on did not clear gone faults");
   chk_clear_hold: assert property (clear_held_s ##0 fault_cause_i == '0 |=> fault_reg == '0) // R09
      else $error("Held clear input did not clear faults");
   chk_cause_keeps: assert property (|fault_cause_i |=> |fault_reg ##1 !fault_free_output_o) // R14
      else $error("Fault with live cause not shown");
   chk_low_setpoint: assert property (!eff[3] && set_mv < `PRIC_SET_MIN_MV |=>
                                      target_speed_o == `PRIC_FULL_SPEED) // R12
      else $error("Low setpoint did not give full speed");
   chk_standby_speed: assert property (eff[3] |=> target_speed_o == $past(standby_reg)) // R06
      else $error("Standby speed not applied");
   chk_relay_one: assert property (relay1_o == ($past(actual_speed_i >= swpoint_reg)
                                               ^ $past(r1_inv_reg))) // R17
      else $error("Relay one wrong against switch point");
   chk_prio_out: assert property ($rose(filt_reg[7]) |=> priority_o [*2]) // R15
      else $error("Priority output did not follow override");
   chk_rx_stop: assert property (rx_valid_o |-> $past(rx_state_reg == pric_pkg::RX_STOP)
                                 && $past(rx_s2_reg)) // R20
      else $error("Character accepted without valid stop");
endmodule

// [verif/pric_plc_model.sv]
// Purpose: Remote controller model driving the command pins and the serial line
// Assumes: Bit time is given in reference clock cycles
// Notes:   Line idles high between characters, as an undriven receiver expects
`timescale 1ns/100ps
module pric_plc_model #(
   parameter int BIT_CYC = 2604
) (
   input  wire logic       ref_clk_i,
   output logic [7:0]      cmd_o,
   output logic            rx_o
);
   // ---------------------------
   // Command pins and serial line
   // ---------------------------
   initial begin
      cmd_o = 8'h00;
      rx_o  = 1'b1;
   end
   task automatic set_cmd(input logic [7:0] v);
      @(posedge ref_clk_i);
      cmd_o <= v;
   endtask
   // start, eight data bits LSB first, stop
   task automatic send_char(input logic [7:0] d);
      logic [9:0] frame;
      frame = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge ref_clk_i);
         rx_o <= frame[i];
         repeat (BIT_CYC - 1) @(posedge ref_clk_i);
      end
   endtask
endmodule

// [verif/testbench.sv]
// Purpose: Self-checking bench for the remote I/O control
// Assumes: Short filter and acknowledge counts for a brief run
// Notes:   Command bits: 0 vent,1 motor,2 station,3 reduced,4 heater,5 seal,6 clear,7 override
`timescale 1ns/100ps
module testbench;
   logic         clk = 1'b0, rst = 1'b1, st_ok = 1'b1, vreq = 1'b0, stb = 1'b0;
   logic         wr = 1'b0, rd = 1'b0, rxv, am, mo, so, vo, ho, sg, sr, ff, pr, r1, r2, r3;
   logic [13:0]  sp = 14'h0000;
   logic [9:0]   act = 10'h0000, raddr = 10'h0000, tgt, ao;
   logic [7:0]   fc = 8'h00, addr = 8'h00, cmd, rxd;
   logic [3:0]   wn = 4'h0;
   logic [31:0]  wd = 32'h0000_0000, rdat;
   logic         line;
   int           err_total = 0, n_tests = 0;
   always #20 clk = ~clk;
   pric_plc_model u_plc (.ref_clk_i(clk), .cmd_o(cmd), .rx_o(line));
   pric_remote_io #(.ACK_CYC(20), .FILT_CYC(4)) u_dut (
      .ref_clk_i(clk), .rst_i(rst), .vent_enable_input_i(cmd[0]), .motor_run_input_i(cmd[1]),
      .station_on_input_i(cmd[2]), .reduced_speed_input_i(cmd[3]), .heater_on_input_i(cmd[4]),
      .seal_gas_input_i(cmd[5]), .fault_clear_input_i(cmd[6]),
      .connector_override_input_i(cmd[7]), .speed_setpoint_analog_i(sp),
      .actual_speed_i(act), .selftest_ok_i(st_ok), .vent_request_i(vreq), .fault_cause_i(fc),
      .warning_i(wn), .rx_i(line), .rx_addr_i(raddr), .rx_addr_stb_i(stb), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .motor_run_o(mo),
      .station_on_o(so), .vent_o(vo), .heater_o(ho), .seal_gas_o(sg), .target_speed_o(tgt),
      .speed_reached_output_o(sr), .fault_free_output_o(ff), .priority_o(pr),
      .speed_analog_output_o(ao), .relay1_o(r1), .relay2_o(r2), .relay3_o(r3),
      .rx_data_o(rxd), .rx_valid_o(rxv), .addr_match_o(am));
   // ---------------------------
   // Shared tasks
   // ---------------------------
   // Compare one result; unknowns never match
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Pin change, then the filter and one register stage must pass
   task automatic pins(input logic [7:0] v);
      u_plc.set_cmd(v);
      tick(12);
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdat;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd   <= d;
      wr   <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // One address strobe, then the registered match pulse is looked at while it stands
   task automatic addr_chk(input logic [9:0] a, input logic e);
      @(posedge clk);
      raddr <= a;
      stb   <= 1'b1;
      @(posedge clk);
      stb <= 1'b0;
      #1 chk(32'(am), 32'(e), "address match");
   endtask
   task automatic wrap_up;
      $display("tests %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ---------------------------
   // Scenarios
   // ---------------------------
   task automatic t_reset;
      logic [31:0] d;
      chk(32'(ff), 1, "fault free at reset");
      chk(32'(r2), 1, "relay two at reset");
      reg_rd(8'h04, d);
      chk(d, 32'd667, "standby default");
      reg_rd(8'h20, d);
      chk(d, 0, "unmapped read");
   endtask
   task automatic t_pump;
      pins(8'h85);
      chk(32'(pr), 1, "priority shown");
      chk(32'(mo), 0, "no motor without pin");
      pins(8'h87);
      chk(32'(mo), 1, "motor runs");
      pins(8'h85);
      chk(32'(vo), 0, "motor stop no vent");
      pins(8'h87);
      chk(32'(mo), 1, "motor restarts");
      st_ok = 1'b0;
      tick(3);
      chk(32'(mo), 0, "no motor without self-test");
      st_ok = 1'b1;
      tick(3);
      pins(8'hB9);
      chk({ho, sg, so}, 3'b110, "heat seal");
      pins(8'h81);
      chk(32'(vo), 1, "vent after stop");
      pins(8'h01);
      chk(32'(pr), 0, "priority off");
   endtask
   task automatic t_speed;
      pins(8'h8C);
      chk(32'(tgt), 32'd667, "standby speed");
      pins(8'h84);
      sp = 14'h1770;
      tick(4);
      chk(32'(tgt), 32'd600, "6 V setpoint");
      sp = 14'h07CF;
      tick(4);
      chk(32'(tgt), 32'd1000, "low setpoint");
      act = 10'd800;
      tick(4);
      chk({sr, r1}, 2'b11, "switch point");
      chk(32'(ao), (800 * 1023) / 1000, "analog out");
      reg_wr(8'h08, 32'd900);
      tick(4);
      chk({sr, r1}, 2'b00, "below point");
   endtask
   task automatic t_fault;
      fc = 8'h01;
      wn = 4'h2;
      tick(4);
      chk({ff, r2, r3}, 3'b001, "fault set");
      fc = 8'h00;
      wn = 4'h0;
      tick(4);
      chk({ff, r3}, 2'b00, "fault held");
      pins(8'hC4);
      tick(30);
      chk({ff, r2}, 2'b11, "fault cleared");
   endtask
   task automatic t_serial;
      int n;
      n = 0;
      // The valid pulse comes mid stop bit, before the model returns
      fork
         u_plc.send_char(8'hA5);
         begin
            while (rxv !== 1'b1 && n < 30000) begin
               tick(1);
               n++;
            end
         end
      join
      chk(32'(n < 30000), 1, "valid pulse seen");
      chk(32'(rxd), 32'h0000_00A5, "character");
      addr_chk(10'd962, 1'b1);
      // Give this unit an address distinct from the others on the bus
      reg_wr(8'h0C, 32'd5);
      addr_chk(10'd5, 1'b1);
      addr_chk(10'd1, 1'b0);
   endtask
   initial begin
      tick(5);
      rst <= 1'b0;
      tick(1);
      t_reset;
      t_pump;
      t_speed;
      t_fault;
      t_serial;
      wrap_up;
   end
   initial begin
      #3200000;
      err_total++;
      wrap_up;
   end
endmodule
